// ### include/cec_params.svh
// Summary of operation
// - Result bit reads one when selected positive input exceeds selected negative input.
// - Raw comparator output is synchronized, result lags one to two clocks.
// - Mux enable set and converter off: channel select picks channel 0-7 as negative.
// - Mux enable clear or converter on: dedicated negative pin is negative input.
// - Bandgap select set feeds internal reference to positive input, else positive pin.
// - Writing comparator-off one powers comparator down; writing zero restores power.
// - Event flag sets when synchronized output shows the transition the mode selects.
// - Mode bits 1:0: 00 toggle, 10 falling, 11 rising, 01 reserved.
// - Event flag clears automatically when the processor enters the comparator vector.
// - Writing one to the event flag clears it; writing zero leaves it.
// - Interrupt requested only with interrupt enable and global interrupt enable set.
// - Capture routing set drives comparator output into the timer capture front end.
// - Capture routing clear keeps comparator output disconnected from timer capture.
// - Mux enable is read/write bit 3 of its register, reset zero.
`ifndef CEC_PARAMS_SVH
`define CEC_PARAMS_SVH
`define CEC_CTRL_OFFSET   6'h08
`define CEC_MUXCFG_OFFSET 6'h30
`define CEC_BIT_OFF       3'd7
`define CEC_BIT_BANDGAP   3'd6
`define CEC_BIT_RESULT    3'd5
`define CEC_BIT_FLAG      3'd4
`define CEC_BIT_IRQ_EN    3'd3
`define CEC_BIT_CAPTURE   3'd2
`define CEC_BIT_MUX_EN    3'd3
`define CEC_BIT_MODE_HI   3'd1
`define CEC_BIT_MODE_LO   3'd0
`define CEC_CTRL_RESET    8'h00
`define CEC_MODE_TOGGLE   2'h0
`define CEC_MODE_FALL     2'h2
`define CEC_MODE_RISE     2'h3
`endif

// ### include/cec_pkg.sv
package cec_pkg;
    // Control fields held in the control and status register.
    typedef struct packed {
        logic       comparator_off;
        logic       bandgap_select;
        logic       compare_irq_enable;
        logic       capture_route_enable;
        logic [1:0] event_mode;
    } cec_ctrl_type;

    // Analog selection sent to the comparator front end.
    typedef struct packed {
        logic       pos_is_bandgap;
        logic       neg_is_channel;
        logic [2:0] neg_channel;
        logic       power_down;
    } cec_select_type;

    // Edge detector states, Gray coded.
    typedef enum logic [1:0] {
        CEC_EDGE_IDLE  = 2'b00,
        CEC_EDGE_PRIME = 2'b01,
        CEC_EDGE_RUN   = 2'b11
    } cec_edge_state_type;
endpackage

// ### logic/cec_sync.sv
`timescale 1ns/1ns
// Two-stage synchronizer for the asynchronous comparator output.
module cec_sync (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic reset_n,
    // Asynchronous level in, synchronized level out.
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage_one;

    // Only the second stage reads the first one.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_one <= 1'b0;
            sync_out  <= 1'b0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule // cec_sync

// ### logic/cec_comparator_event.sv
`timescale 1ns/1ns
`include "cec_params.svh"
module cec_comparator_event
    import cec_pkg::*;
(
    // Clock and reset.
    input  wire logic           clock,
    input  wire logic           reset_n,
    // Register port, I/O space.
    input  wire logic [5:0]     io_addr,
    input  wire logic           io_write,
    input  wire logic           io_read,
    input  wire logic [7:0]     io_wdata,
    output logic [7:0]          io_rdata,
    // Processor context.
    input  wire logic           global_irq_enable,
    input  wire logic           irq_vector_ack,
    output logic                compare_irq,
    // Converter state sampled from its registers.
    input  wire logic           converter_enable,
    input  wire logic [2:0]     channel_select,
    // Analog front end: raw comparator result and input selection.
    input  wire logic           comparator_raw,
    output cec_select_type      analog_select,
    // Timer capture front end.
    output logic                capture_source_select,
    output logic                capture_compare_in
);
    cec_ctrl_type       ctrl;
    logic               neg_input_mux_enable;
    logic               compare_event_flag;
    logic               compare_sync;
    logic               compare_result;
    logic               compare_prev;
    logic               event_hit;
    logic               wr_ctrl;
    logic               wr_mux;
    cec_edge_state_type edge_state;

    assign wr_ctrl = io_write && (io_addr == `CEC_CTRL_OFFSET);
    assign wr_mux  = io_write && (io_addr == `CEC_MUXCFG_OFFSET);

    // Synchronize the raw comparator output; a powered-down comparator reads low.
    cec_sync u_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in (comparator_raw && !ctrl.comparator_off),
        .sync_out (compare_sync)
    );

    // Readable result bit is the synchronized comparator output.
    assign compare_result = compare_sync;

    // Control register fields.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= cec_ctrl_type'(6'h00);
        end else if (wr_ctrl) begin
            ctrl.comparator_off       <= io_wdata[`CEC_BIT_OFF];
            ctrl.bandgap_select       <= io_wdata[`CEC_BIT_BANDGAP];
            ctrl.compare_irq_enable   <= io_wdata[`CEC_BIT_IRQ_EN];
            ctrl.capture_route_enable <= io_wdata[`CEC_BIT_CAPTURE];
            ctrl.event_mode           <= io_wdata[`CEC_BIT_MODE_HI:`CEC_BIT_MODE_LO];
        end
    end

    // Multiplexer enable, bit 3 of the mux configuration register.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            neg_input_mux_enable <= 1'b0;
        end else if (wr_mux) begin
            neg_input_mux_enable <= io_wdata[`CEC_BIT_MUX_EN];
        end
    end

    // Edge detector: primes its history one cycle after reset before comparing.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            edge_state   <= CEC_EDGE_IDLE;
            compare_prev <= 1'b0;
        end else begin
            compare_prev <= compare_sync;
            case (edge_state)
                CEC_EDGE_IDLE:  edge_state <= CEC_EDGE_PRIME;
                CEC_EDGE_PRIME: edge_state <= CEC_EDGE_RUN;
                CEC_EDGE_RUN:   edge_state <= CEC_EDGE_RUN;
                default:        edge_state <= CEC_EDGE_IDLE;
            endcase
        end
    end

    // Event selection by mode; the reserved code never fires.
    always_comb begin
        event_hit = 1'b0;
        if (edge_state == CEC_EDGE_RUN) begin
            case (ctrl.event_mode)
                `CEC_MODE_TOGGLE: event_hit = compare_sync != compare_prev;
                `CEC_MODE_FALL:   event_hit = !compare_sync && compare_prev;
                `CEC_MODE_RISE:   event_hit = compare_sync && !compare_prev;
                default:          event_hit = 1'b0;
            endcase
        end
    end

    // Event flag: a new event wins over a vector or software clear.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            compare_event_flag <= 1'b0;
        end else if (event_hit) begin
            compare_event_flag <= 1'b1;
        end else if (irq_vector_ack) begin
            compare_event_flag <= 1'b0;
        end else if (wr_ctrl && io_wdata[`CEC_BIT_FLAG]) begin
            compare_event_flag <= 1'b0;
        end
    end

    // Interrupt request, registered: held while flag and both enables are set and no vector acknowledge is present.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            compare_irq <= 1'b0;
        end else begin
            compare_irq <= compare_event_flag && ctrl.compare_irq_enable
                           && global_irq_enable && !irq_vector_ack;
        end
    end

    // Analog input selection.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            analog_select <= cec_select_type'(6'h00);
        end else begin
            analog_select.pos_is_bandgap <= ctrl.bandgap_select;
            analog_select.neg_is_channel <= neg_input_mux_enable
                                            && !converter_enable;
            analog_select.neg_channel    <= (neg_input_mux_enable && !converter_enable)
                                            ? channel_select : 3'h0;
            analog_select.power_down     <= ctrl.comparator_off;
        end
    end

    // Timer capture routing; output held low when not routed.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            capture_source_select <= 1'b0;
            capture_compare_in    <= 1'b0;
        end else begin
            capture_source_select <= ctrl.capture_route_enable;
            capture_compare_in    <= ctrl.capture_route_enable && compare_sync;
        end
    end

    // Register read data; unmapped addresses read zero.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            io_rdata <= 8'h00;
        end else if (io_read && io_addr == `CEC_CTRL_OFFSET) begin
            io_rdata <= {ctrl.comparator_off, ctrl.bandgap_select, compare_result,
                         compare_event_flag, ctrl.compare_irq_enable,
                         ctrl.capture_route_enable, ctrl.event_mode};
        end else if (io_read && io_addr == `CEC_MUXCFG_OFFSET) begin
            io_rdata <= {4'h0, neg_input_mux_enable, 3'h0};
        end else begin
            io_rdata <= 8'h00;
        end
    end

    // Flag sets one cycle after a detected edge.
    property p_flag_set;
        @(posedge clock) disable iff (!reset_n)
        event_hit |=> compare_event_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Event flag not set.");

    property p_soft_clear;
        @(posedge clock) disable iff (!reset_n)
        (wr_ctrl && io_wdata[`CEC_BIT_FLAG] && !event_hit) |=> !compare_event_flag;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("Flag not cleared.");

    property p_vector_clear;
        @(posedge clock) disable iff (!reset_n)
        (irq_vector_ack && !event_hit) |=> !compare_event_flag;
    endproperty
    a_vector_clear: assert property (p_vector_clear) else $error("Vector clear lost.");

    property p_irq_gate;
        @(posedge clock) disable iff (!reset_n)
        compare_irq |-> $past(ctrl.compare_irq_enable) && $past(global_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Interrupt without enable.");

    property p_irq_hold;
        @(posedge clock) disable iff (!reset_n)
        (compare_event_flag && ctrl.compare_irq_enable && global_irq_enable
         && !irq_vector_ack) |=> compare_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("Interrupt dropped.");

    // A level that has been sampled twice has reached the second stage by the next edge.
    property p_sync_lag;
        @(posedge clock) disable iff (!reset_n)
        $rose(comparator_raw && !ctrl.comparator_off) ##1
        (comparator_raw && !ctrl.comparator_off) |=> compare_result;
    endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("Result lag too long.");

    property p_capture_off;
        @(posedge clock) disable iff (!reset_n)
        !ctrl.capture_route_enable |=> !capture_compare_in;
    endproperty
    a_capture_off: assert property (p_capture_off) else $error("Capture leaks.");

    property p_neg_pin;
        @(posedge clock) disable iff (!reset_n)
        (!neg_input_mux_enable || converter_enable) |=> !analog_select.neg_is_channel;
    endproperty
    a_neg_pin: assert property (p_neg_pin) else $error("Negative pin not selected.");

    property p_reserved;
        @(posedge clock) disable iff (!reset_n)
        (ctrl.event_mode == 2'h1 && !compare_event_flag) |=> !compare_event_flag;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved mode fired.");
endmodule // cec_comparator_event

// ### tb/cec_analog_model.sv
`timescale 1ns/1ns
// Analog pins and comparator seen by the block, with voltages given as codes.
module cec_analog_model
    import cec_pkg::*;
#(
    parameter logic [7:0] BANDGAP_LEVEL = 8'h40
) (
    // Input selection from the block.
    input  wire cec_select_type analog_select,
    // Pin voltages.
    input  wire logic [7:0]     pos_level,
    input  wire logic [7:0]     neg_level,
    input  wire logic [7:0]     chan_level [8],
    // Raw comparator output.
    output logic                comparator_raw
);
    logic [7:0] pos_in;
    logic [7:0] neg_in;

    // The multiplexers choose what each comparator input sees.
    assign pos_in = analog_select.pos_is_bandgap ? BANDGAP_LEVEL : pos_level;
    assign neg_in = analog_select.neg_is_channel ? chan_level[analog_select.neg_channel]
                                                 : neg_level;
    // A powered-down comparator gives a low output.
    assign comparator_raw = !analog_select.power_down && (pos_in > neg_in);
endmodule // cec_analog_model

// ### tb/testbench.sv
`timescale 1ns/1ns
`include "cec_params.svh"
module testbench;
    import cec_pkg::*;
    localparam logic [5:0] CTRL = `CEC_CTRL_OFFSET;
    localparam logic [5:0] MUXC = `CEC_MUXCFG_OFFSET;
    logic           clock = 1'b0;
    logic           reset_n = 1'b0;
    logic [5:0]     io_addr = 6'h00;
    logic           io_write = 1'b0;
    logic           io_read = 1'b0;
    logic [7:0]     io_wdata = 8'h00;
    logic [7:0]     io_rdata;
    logic           global_irq_enable = 1'b0;
    logic           irq_vector_ack = 1'b0;
    logic           compare_irq;
    logic           converter_enable = 1'b0;
    logic [2:0]     channel_select = 3'h0;
    logic           comparator_raw;
    cec_select_type analog_select;
    logic           capture_source_select;
    logic           capture_compare_in;
    logic [7:0]     pos_level = 8'h80;
    logic [7:0]     neg_level = 8'hff;
    logic [7:0]     chan_level [8] = '{default: 8'h10};
    logic [7:0]     rd_val;
    int             num_errors = 0;
    int             n_compared = 0;

    // Free-running system clock.
    always #4 clock = ~clock;

    cec_comparator_event dut (.clock(clock), .reset_n(reset_n), .io_addr(io_addr),
        .io_write(io_write), .io_read(io_read), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
        .compare_irq(compare_irq), .converter_enable(converter_enable),
        .channel_select(channel_select), .comparator_raw(comparator_raw),
        .analog_select(analog_select), .capture_source_select(capture_source_select),
        .capture_compare_in(capture_compare_in));

    cec_analog_model pins (.analog_select(analog_select), .pos_level(pos_level),
        .neg_level(neg_level), .chan_level(chan_level), .comparator_raw(comparator_raw));

    // Compares a seen value with the expected one and counts both.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Waits a number of falling edges.
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // One-cycle register write.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        io_addr = a;
        io_wdata = d;
        io_write = 1'b1;
        @(negedge clock);
        io_write = 1'b0;
    endtask

    // One-cycle register read; data lands one cycle after the strobe.
    task automatic rd(input logic [5:0] a);
        @(negedge clock);
        io_addr = a;
        io_read = 1'b1;
        @(negedge clock);
        io_read = 1'b0;
        rd_val = io_rdata;
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Reset values and an unmapped address.
    task automatic t_reset;
        rd(CTRL);
        chk(rd_val, 8'h00);
        rd(MUXC);
        chk(rd_val, 8'h00);
        rd(6'h3f);
        chk(rd_val, 8'h00);
        $display("test reset done");
    endtask

    // Negative input routing, bandgap and power-down.
    task automatic t_mux;
        wr(MUXC, 8'h08);
        rd(MUXC);
        chk(rd_val, 8'h08);
        for (int i = 0; i < 8; i++) begin
            channel_select = 3'(i);
            cyc(2);
            chk({2'b00, analog_select}, {4'b0001, 3'(i), 1'b0});
        end
        converter_enable = 1'b1;
        cyc(2);
        chk({2'b00, analog_select}, 8'h00);
        converter_enable = 1'b0;
        wr(MUXC, 8'h00);
        cyc(2);
        chk({2'b00, analog_select}, 8'h00);
        wr(CTRL, 8'h40);
        cyc(2);
        chk({2'b00, analog_select}, 8'h20);
        wr(CTRL, 8'h80);
        neg_level = 8'h00;
        cyc(4);
        chk({2'b00, analog_select}, 8'h01);
        rd(CTRL);
        // Enabling the channel routing toggled the result, so the flag is still set here.
        chk(rd_val, 8'h90);
        wr(CTRL, 8'h00);
        cyc(4);
        rd(CTRL);
        chk(rd_val, 8'h30);
        wr(CTRL, 8'h10);
        rd(CTRL);
        chk(rd_val, 8'h20);
        neg_level = 8'hff;
        cyc(4);
        $display("test mux done");
    endtask

    // Each event mode against a rising and a falling result; enable stays low.
    task automatic t_edges;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(CTRL, {6'h04, m});
            neg_level = 8'h00;
            cyc(5);
            rd(CTRL);
            chk(rd_val, {3'b001, m == 2'h0 || m == 2'h3, 2'b00, m});
            wr(CTRL, {6'h04, m});
            neg_level = 8'hff;
            cyc(5);
            rd(CTRL);
            chk(rd_val, {3'b000, m == 2'h0 || m == 2'h2, 2'b00, m});
        end
        $display("test edges done");
    endtask

    // Interrupt gating, holding and clearing by the vector.
    task automatic t_irq;
        wr(CTRL, 8'h13);
        wr(CTRL, 8'h0b);
        neg_level = 8'h00;
        cyc(5);
        chk(compare_irq, 1'b0);
        rd(CTRL);
        chk(rd_val, 8'h3b);
        global_irq_enable = 1'b1;
        // Bounded wait for the request; running out is a mismatch and ends the run.
        for (int k = 0; k < 8 && compare_irq !== 1'b1; k++)
            cyc(1);
        if (compare_irq !== 1'b1) begin
            chk(compare_irq, 1'b1);
            end_of_test;
        end
        wr(CTRL, 8'h0b);
        cyc(2);
        chk(compare_irq, 1'b1);
        irq_vector_ack = 1'b1;
        cyc(1);
        irq_vector_ack = 1'b0;
        cyc(1);
        chk(compare_irq, 1'b0);
        rd(CTRL);
        chk(rd_val, 8'h2b);
        wr(CTRL, 8'h03);
        neg_level = 8'hff;
        cyc(4);
        $display("test irq done");
    endtask

    // Capture routing connects and disconnects the result.
    task automatic t_capture;
        neg_level = 8'h00;
        cyc(5);
        chk({capture_source_select, capture_compare_in}, 8'h00);
        wr(CTRL, 8'h04);
        cyc(3);
        chk({capture_source_select, capture_compare_in}, 8'h03);
        neg_level = 8'hff;
        cyc(5);
        chk({capture_source_select, capture_compare_in}, 8'h02);
        wr(CTRL, 8'h00);
        $display("test capture done");
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        cyc(2);
        t_reset;
        t_mux;
        t_edges;
        t_irq;
        t_capture;
        end_of_test;
    end
endmodule // testbench
